// ---- hdl/erd_pkg.sv ----
// Package of constants and types for the serial EEPROM read logic
// Overview of operation
// - Read header: acknowledge, send byte at current address
// - Master not-acknowledge plus STOP returns to standby
// - Dummy write loads all ten address bits
// - Keep sending while master acknowledges each byte
// - Array reads wrap only at memory end
// - Secure page read uses special header 1011b
// - Secure page reads wrap inside page
// - Setup register reads with don't-care bits one
// - Acknowledged setup register byte repeats
// - Unique ID selected by address byte 01xx0000
// - Unique ID sixteen bytes, wraps to first
// - Secure page address acked only while unlocked
// - Lock status byte bit one shows lock
// - Array delivered holding all FFh
// - Setup register delivered reading 7Dh
// - Header 1010 or 1011, select bit must match
// - Release data line during ninth clock when reading
`default_nettype none
package erd_pkg;
  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [3:0] ERD_HDR_ARRAY = 4'ha;  // Array access header
  localparam logic [3:0] ERD_HDR_SPEC = 4'hb;   // Special access header
  localparam logic [7:0] ERD_ERASED = 8'hff;    // Delivered array byte
  localparam logic [7:0] ERD_SETUP_RST = 8'h7d; // Delivered setup register
  localparam logic [7:0] ERD_SETUP_ONES = 8'h7d;// Don't-care bits of setup register
  localparam int ERD_SEL_POS = 7;               // Address select bit
  localparam int ERD_WLOCK_POS = 1;             // Array write lock bit
  localparam int ERD_LOCK_POS = 1;              // Lock flag in lock status byte
  localparam logic [1:0] ERD_SEL_SPAGE = 2'h0;  // Address byte 00xx: secure page
  localparam logic [1:0] ERD_SEL_UID = 2'h1;    // Address byte 01xx: unique ID
  localparam logic [1:0] ERD_SEL_LOCK = 2'h2;   // Address byte 10xx: lock status
  localparam logic [1:0] ERD_SEL_SETUP = 2'h3;  // Address byte 11xx: setup register
  localparam logic [3:0] ERD_BITS = 4'h8;       // Bits per byte
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ERD_IDLE, ERD_RXDEV, ERD_ACKDEV, ERD_RXADR, ERD_ACKADR,
    ERD_RXDAT, ERD_ACKDAT, ERD_TX, ERD_RACK
  } erd_fsm_e;
  // Whole state of the read logic
  typedef struct packed {
    erd_fsm_e fsm;
    logic [2:0] scl_sy;            // Clock pin synchroniser
    logic [2:0] sda_sy;            // Data pin synchroniser
    logic scl_f;                   // Filtered clock level
    logic sda_f;                   // Filtered data level
    logic [7:0] sh;                // Receive shifter
    logic [3:0] cnt;               // Bit counter
    logic rw;                      // Read requested
    logic spec;                    // Special header in use
    logic [1:0] hi;                // Upper address bits from header
    logic [9:0] addr;              // Current array address
    logic [3:0] sidx;              // Secure page or ID index
    logic [1:0] sel;               // Special target
    logic nack;                    // Master did not acknowledge
    logic oe;                      // Data line pulled low
    logic standby;                 // Waiting for START
    logic [7:0] tx;                // Transmit shifter
    logic [7:0] setup;             // Setup register image
    logic lock;                    // Secure page locked
    logic [15:0][7:0] spage;       // Secure page
    logic [1023:0][7:0] mem;       // Array
  } erd_state_s;
endpackage
`default_nettype wire

// ---- hdl/erd_read.sv ----
// Serial EEPROM two-wire slave read logic
`default_nettype none
module erd_read #(
  parameter logic [127:0] UID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210 // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Content load port, core clock domain
  input wire logic ld_en,
  input wire logic ld_spage,
  input wire logic [9:0] ld_addr,
  input wire logic [7:0] ld_data,
  input wire logic setup_ld_en,
  input wire logic [7:0] setup_ld_data,
  input wire logic lock_set,
  // Status
  output logic standby
);
  // ****************************************
  // State and edges
  // ****************************************
  erd_pkg::erd_state_s st;       // Registered state
  erd_pkg::erd_state_s next_st;  // Next state
  logic next_scl;                // Clock level after filter
  logic next_sda;                // Data level after filter
  logic rise;                    // Clock rising
  logic fall;                    // Clock falling
  logic start_c;                 // START seen
  logic stop_c;                  // STOP seen
  logic [7:0] cur_byte;          // Byte the read source offers

  // A change counts only once the second and third stages agree
  assign next_scl = (st.scl_sy[1] == st.scl_sy[2]) ? st.scl_sy[2] : st.scl_f;
  assign next_sda = (st.sda_sy[1] == st.sda_sy[2]) ? st.sda_sy[2] : st.sda_f;
  assign rise = next_scl & ~st.scl_f;
  assign fall = ~next_scl & st.scl_f;
  assign start_c = st.scl_f & next_scl & st.sda_f & ~next_sda;
  assign stop_c = st.scl_f & next_scl & ~st.sda_f & next_sda;

  // Open drain: only the enable moves, the level is always low
  assign sda_out = 1'b0;
  assign sda_oe = st.oe;
  assign standby = st.standby;

  // ****************************************
  // Read source
  // ****************************************
  // Byte offered by the current target; shared by first and later bytes
  function automatic logic [7:0] src_byte(input erd_pkg::erd_state_s s);
    logic [7:0] b;
    b = s.mem[s.addr];
    if (s.spec) begin
      case (s.sel)
        erd_pkg::ERD_SEL_SPAGE: b = s.spage[s.sidx];
        erd_pkg::ERD_SEL_UID: b = UID[8'(127 - 8 * s.sidx) -: 8];
        erd_pkg::ERD_SEL_LOCK: begin
          b = 8'h00;
          b[erd_pkg::ERD_LOCK_POS] = s.lock;
        end
        default: b = s.setup | erd_pkg::ERD_SETUP_ONES;
      endcase
    end
    return b;
  endfunction

  assign cur_byte = src_byte(st);

  // ****************************************
  // Next state
  // ****************************************
  // Bus protocol engine; START and STOP win over bit activity
  always_comb begin
    next_st = st;
    next_st.scl_sy = {st.scl_sy[1:0], scl_in};
    next_st.sda_sy = {st.sda_sy[1:0], sda_in};
    next_st.scl_f = next_scl;
    next_st.sda_f = next_sda;
    // Content loads stand in for the write path, which lives elsewhere
    if (ld_en && !ld_spage) begin
      next_st.mem[ld_addr] = ld_data;
    end
    if (ld_en && ld_spage) begin
      next_st.spage[ld_addr[3:0]] = ld_data;
    end
    if (setup_ld_en) begin
      next_st.setup = setup_ld_data;
    end
    if (lock_set) begin
      next_st.lock = 1'b1;
    end
    if (start_c) begin
      // Repeated START also lands here, ending any transfer
      next_st.fsm = erd_pkg::ERD_RXDEV;
      next_st.cnt = 4'h0;
      next_st.oe = 1'b0;
    end else if (stop_c) begin
      next_st.fsm = erd_pkg::ERD_IDLE;
      next_st.oe = 1'b0;
    end else begin
      case (st.fsm)
        erd_pkg::ERD_RXDEV, erd_pkg::ERD_RXADR, erd_pkg::ERD_RXDAT: begin
          if (rise && st.cnt != erd_pkg::ERD_BITS) begin
            next_st.sh = {st.sh[6:0], next_sda};
            next_st.cnt = st.cnt + 4'h1;
          end
          if (fall && st.cnt == erd_pkg::ERD_BITS) begin
            next_st.cnt = 4'h0;
            if (st.fsm == erd_pkg::ERD_RXDEV) begin
              // Header and matching select bit, else ignore the frame
              if ((st.sh[7:4] == erd_pkg::ERD_HDR_ARRAY || st.sh[7:4] == erd_pkg::ERD_HDR_SPEC) &&
                  st.sh[3] == st.setup[erd_pkg::ERD_SEL_POS]) begin
                next_st.fsm = erd_pkg::ERD_ACKDEV;
                next_st.oe = 1'b1;
                next_st.rw = st.sh[0];
                next_st.spec = (st.sh[7:4] == erd_pkg::ERD_HDR_SPEC);
                if (!st.sh[0] && st.sh[7:4] == erd_pkg::ERD_HDR_ARRAY) begin
                  next_st.hi = st.sh[2:1];
                end
              end else begin
                next_st.fsm = erd_pkg::ERD_IDLE;
              end
            end else if (st.fsm == erd_pkg::ERD_RXADR) begin
              next_st.fsm = erd_pkg::ERD_ACKADR;
              next_st.oe = 1'b1;
              if (!st.spec) begin
                next_st.addr = {st.hi, st.sh};
              end else begin
                next_st.sel = st.sh[7:6];
                next_st.sidx = (st.sh[7:6] == erd_pkg::ERD_SEL_SPAGE) ? st.sh[3:0] : 4'h0;
                if (st.sh[7:6] == erd_pkg::ERD_SEL_SPAGE && st.lock) begin
                  // Refused address byte doubles as the lock probe
                  next_st.fsm = erd_pkg::ERD_IDLE;
                  next_st.oe = 1'b0;
                end
              end
            end else begin
              // Written data is accepted and left to the write path
              next_st.fsm = erd_pkg::ERD_ACKDAT;
              next_st.oe = 1'b1;
            end
          end
        end
        erd_pkg::ERD_ACKDEV: begin
          if (fall) begin
            if (st.rw) begin
              // First data bit goes out on the same falling edge
              next_st.fsm = erd_pkg::ERD_TX;
              next_st.tx = cur_byte;
              next_st.oe = ~cur_byte[7];
            end else begin
              next_st.fsm = erd_pkg::ERD_RXADR;
              next_st.oe = 1'b0;
            end
          end
        end
        erd_pkg::ERD_ACKADR, erd_pkg::ERD_ACKDAT: begin
          if (fall) begin
            next_st.fsm = erd_pkg::ERD_RXDAT;
            next_st.oe = 1'b0;
          end
        end
        erd_pkg::ERD_TX: begin
          if (fall) begin
            if (st.cnt == erd_pkg::ERD_BITS - 4'h1) begin
              next_st.fsm = erd_pkg::ERD_RACK;
              next_st.oe = 1'b0;
            end else begin
              next_st.cnt = st.cnt + 4'h1;
              next_st.tx = {st.tx[6:0], 1'b1};
              next_st.oe = ~st.tx[6];
            end
          end
        end
        erd_pkg::ERD_RACK: begin
          if (rise) begin
            next_st.nack = next_sda;
            // Pointer moves once per byte sent, acknowledged or not
            if (!st.spec) begin
              next_st.addr = st.addr + 10'h001;
            end else if (st.sel == erd_pkg::ERD_SEL_SPAGE || st.sel == erd_pkg::ERD_SEL_UID) begin
              next_st.sidx = st.sidx + 4'h1;
            end
          end
          if (fall) begin
            next_st.cnt = 4'h0;
            if (!st.nack) begin
              // Setup and lock targets do not move, so they repeat
              next_st.fsm = erd_pkg::ERD_TX;
              next_st.tx = cur_byte;
              next_st.oe = ~cur_byte[7];
            end else begin
              next_st.fsm = erd_pkg::ERD_IDLE;
            end
          end
        end
        default: begin
          next_st.oe = 1'b0;
        end
      endcase
    end
    next_st.standby = (next_st.fsm == erd_pkg::ERD_IDLE);
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset gives the delivered contents
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.scl_sy <= 3'h7;
      st.sda_sy <= 3'h7;
      st.scl_f <= 1'b1;
      st.sda_f <= 1'b1;
      st.standby <= 1'b1;
      st.setup <= erd_pkg::ERD_SETUP_RST;
      st.spage <= {16{erd_pkg::ERD_ERASED}};
      st.mem <= {1024{erd_pkg::ERD_ERASED}};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_dev_ack_drive: assert property (st.fsm == erd_pkg::ERD_ACKDEV |-> st.oe)
    else $error("slave address not acknowledged");
  a_read_starts_tx: assert property (st.fsm == erd_pkg::ERD_ACKDEV && st.rw && fall
    && !start_c && !stop_c |=> st.fsm == erd_pkg::ERD_TX && st.tx == $past(cur_byte))
    else $error("read did not start with current byte");
  a_ninth_release: assert property (st.fsm == erd_pkg::ERD_RACK |-> !st.oe)
    else $error("data line held during master acknowledge");
  a_nack_standby: assert property (st.fsm == erd_pkg::ERD_RACK && st.nack && fall && !start_c
    |=> st.standby && !st.oe)
    else $error("no standby after not-acknowledge");
  a_ack_continue: assert property (st.fsm == erd_pkg::ERD_RACK && !st.nack && fall
    && !start_c && !stop_c |=> st.fsm == erd_pkg::ERD_TX ##1 st.fsm == erd_pkg::ERD_TX)
    else $error("transmit stopped despite acknowledge");
  a_array_wrap: assert property (st.fsm == erd_pkg::ERD_RACK && rise && !st.spec
    && !start_c && !stop_c |=> st.addr == $past(st.addr) + 10'h001)
    else $error("array address not advanced");
  a_spage_wrap: assert property (st.fsm == erd_pkg::ERD_RACK && rise && st.spec
    && !start_c && !stop_c && st.sel == erd_pkg::ERD_SEL_SPAGE && st.sidx == 4'hf |=> st.sidx == 4'h0)
    else $error("secure page index did not wrap");
  a_setup_ones: assert property (st.fsm == erd_pkg::ERD_TX && st.cnt == 4'h0 && st.spec
    && st.sel == erd_pkg::ERD_SEL_SETUP |-> (st.tx & erd_pkg::ERD_SETUP_ONES) == erd_pkg::ERD_SETUP_ONES)
    else $error("setup register don't-care bits not one");
  a_lock_refuse: assert property (st.fsm == erd_pkg::ERD_RXADR && fall && st.spec
    && st.cnt == erd_pkg::ERD_BITS && !start_c && !stop_c && st.sh[7:6] == erd_pkg::ERD_SEL_SPAGE
    && st.lock |=> !st.oe [*2])
    else $error("locked secure page acknowledged");
  a_addr_load: assert property (st.fsm == erd_pkg::ERD_RXADR && fall && !st.spec
    && st.cnt == erd_pkg::ERD_BITS && !start_c && !stop_c |=> st.addr == {$past(st.hi), $past(st.sh)})
    else $error("address counter not loaded from ten bits");

  c_array_read: cover property (st.fsm == erd_pkg::ERD_RACK && !st.spec && !st.nack && fall);
  c_spage_wrap: cover property (st.fsm == erd_pkg::ERD_RACK && st.spec && st.sel == erd_pkg::ERD_SEL_SPAGE
    && st.sidx == 4'hf && rise);
  c_uid_read: cover property (st.fsm == erd_pkg::ERD_TX && st.spec && st.sel == erd_pkg::ERD_SEL_UID);
  c_lock_probe: cover property (st.fsm == erd_pkg::ERD_RXADR && st.lock && st.spec && fall &&
    st.cnt == erd_pkg::ERD_BITS);
endmodule
`default_nettype wire

// ---- tb/erd_mst.sv ----
// Two-wire bus master model that drives the EEPROM read logic
`default_nettype none
module erd_mst (
  // Timing reference
  input wire logic core_clk,
  // Bus lines
  input wire logic sda_bus,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Bus sequences
  // ****************************************
  // Bus idle high; the clock stands still outside frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Wait n core cycles; all changes land on falling edges
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // START, also a repeated START; long low phase lets the slave release first
  task automatic start();
    w(1);
    sda_pull = 1'b0;
    w(6);
    scl = 1'b1;
    w(4);
    sda_pull = 1'b1;
    w(4);
    scl = 1'b0;
  endtask
  // STOP: data rises while the clock is high
  task automatic stop();
    w(1);
    sda_pull = 1'b1;
    w(6);
    scl = 1'b1;
    w(4);
    sda_pull = 1'b0;
    w(4);
  endtask
  // One bus clock of 8 core cycles; sampled late in the high phase since
  // the slave answers about 4 core cycles after the clock falls
  task automatic bt(input logic b, output logic r);
    w(1);
    sda_pull = ~b;
    w(4);
    scl = 1'b1;
    w(2);
    r = sda_bus;
    w(1);
    scl = 1'b0;
  endtask
  // Send a byte MSB first, then sample the slave acknowledge
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], r);
    end
    bt(1'b1, r);
    ack = ~r;
  endtask
  // Take a byte, then acknowledge or not; nine is the line seen in the ninth clock
  task automatic rd(output logic [7:0] d, input logic ack, output logic nine);
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, d[i]);
    end
    bt(~ack, nine);
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the EEPROM read logic
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // Unique ID for this run; arbitrary value
  localparam logic [127:0] UID_V = 128'hc3a5_1e0f_7788_9abc_d001_2468_ace0_5b6d;
  logic core_clk, nrst, scl, sda_pull, sda_out, sda_oe, standby;
  logic ld_en, ld_spage, setup_ld_en, lock_set, ak, nine;
  logic [9:0] ld_addr;
  logic [7:0] ld_data, setup_ld_data;
  logic [7:0] q [17];  // Bytes of the last read
  logic [31:0] rows [6];  // Dummy header, address byte, two expected bytes
  int err_total, n_checks, cyc;
  // Open-drain line with pull-up; the device pulls only while enabled and showing a low level
  wire sda_w = !((sda_oe && !sda_out) || sda_pull);
  erd_read #(.UID(UID_V)) i_dut (.core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .ld_en(ld_en), .ld_spage(ld_spage), .ld_addr(ld_addr),
    .ld_data(ld_data), .setup_ld_en(setup_ld_en), .setup_ld_data(setup_ld_data), .lock_set(lock_set),
    .standby(standby));
  erd_mst i_mst (.core_clk(core_clk), .sda_bus(sda_w), .scl(scl), .sda_pull(sda_pull));
  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Run needs about 6300 cycles; a hang is cut well after that
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Load one array or secure page byte with a one-cycle pulse
  task automatic load(input logic sp, input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk);
    ld_en = 1'b1;
    ld_spage = sp;
    ld_addr = a;
    ld_data = d;
    @(negedge core_clk);
    ld_en = 1'b0;
  endtask
  // Dummy write: header must be taken; address acknowledge left in ak
  task automatic dummy(input logic [7:0] h, input logic [7:0] a);
    i_mst.start();
    i_mst.wr(h, ak);
    `CHK(ak, 1'b1)
    i_mst.wr(a, ak);
  endtask
  // Read n bytes, acknowledging all but the last, then STOP
  task automatic rd(input logic [7:0] h, input int n);
    i_mst.start();
    i_mst.wr({h[7:1], 1'b1}, ak);
    `CHK(ak, 1'b1)
    for (int i = 0; i < n; i++) begin
      i_mst.rd(q[i], i < n - 1, nine);
    end
    `CHK(nine, 1'b1)
    i_mst.stop();
    `CHK(standby, 1'b1)
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    ld_en = 1'b0;
    ld_spage = 1'b0;
    ld_addr = 10'h000;
    ld_data = 8'h00;
    setup_ld_en = 1'b0;
    setup_ld_data = 8'h00;
    lock_set = 1'b0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    `CHK(standby, 1'b1)
    `CHK(sda_oe, 1'b0)
    i_mst.w(4);
    // Delivered array is erased
    rd(8'ha0, 2);
    `CHK(q[0], 8'hff)
    `CHK(q[1], 8'hff)
    // Contents around the memory end, a page boundary and the secure page end
    load(1'b0, 10'h3ff, 8'h5a);
    load(1'b0, 10'h000, 8'ha5);
    load(1'b0, 10'h00f, 8'h11);
    load(1'b0, 10'h010, 8'h22);
    load(1'b0, 10'h011, 8'h66);
    load(1'b1, 10'h00f, 8'h33);
    load(1'b1, 10'h000, 8'h44);
    rows = '{32'ha6ff5aa5, 32'ha00f1122, 32'hb00f3344, 32'hb0c07d7d, 32'hb0800000,
      {8'hb0, 8'h40, UID_V[127:112]}};
    foreach (rows[i]) begin
      dummy(rows[i][31:24], rows[i][23:16]);
      `CHK(ak, 1'b1)
      rd(rows[i][31:24], 2);
      `CHK(q[0], rows[i][15:8])
      `CHK(q[1], rows[i][7:0])
    end
    // Array pointer sits after 0x010; special reads must not move it
    rd(8'ha0, 1);
    `CHK(q[0], 8'h66)
    // Full unique ID plus one byte to see the wrap
    dummy(8'hb0, 8'h40);
    rd(8'hb0, 17);
    for (int i = 0; i < 17; i++) begin
      `CHK(q[i], UID_V[127 - 8 * (i % 16) -: 8])
    end
    // Lock probe before and after locking, each closed by START and STOP
    dummy(8'hb0, 8'h00);
    `CHK(ak, 1'b1)
    i_mst.start();
    i_mst.stop();
    @(negedge core_clk);
    lock_set = 1'b1;
    @(negedge core_clk);
    lock_set = 1'b0;
    dummy(8'hb0, 8'h00);
    `CHK(ak, 1'b0)
    i_mst.start();
    i_mst.stop();
    dummy(8'hb0, 8'h80);
    rd(8'hb0, 1);
    `CHK(q[0], 8'h02)
    // Wrong select bit is refused; after moving it the register reads back
    i_mst.start();
    i_mst.wr(8'ha9, ak);
    `CHK(ak, 1'b0)
    i_mst.stop();
    setup_ld_data = 8'h80;
    setup_ld_en = 1'b1;
    @(negedge core_clk);
    setup_ld_en = 1'b0;
    dummy(8'hb8, 8'hc0);
    rd(8'hb8, 1);
    `CHK(q[0], 8'hfd)
    // Reset in mid-run brings back the delivered contents and select bit
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(sda_oe, 1'b0)
    nrst = 1'b1;
    `CHK(standby, 1'b1)
    i_mst.w(4);
    // A data byte after the address is taken, then a selective read follows
    dummy(8'ha0, 8'h11);
    i_mst.wr(8'h00, ak);
    `CHK(ak, 1'b1)
    rd(8'ha0, 1);
    `CHK(q[0], 8'hff)
    dummy(8'hb0, 8'hc0);
    rd(8'hb0, 1);
    `CHK(q[0], 8'h7d)
    end_of_test();
  end
endmodule
`default_nettype wire
